// ---- core/crf_clock_ready_regs.sv ----
// Clock-ready interrupt flags and APB2 peripheral soft-reset register, APB slave.
// Assumes stable indications arrive asynchronously and software keeps reserved bits zero.
//
// What this block does
// - Third PLL stable while enabled sets its flag; write-one clear resets it.
// - Second PLL stable flag at bit 5, set when stable and enabled, held until cleared.
// - Main PLL stable flag at bit 4, cleared only by reset or software write-one clear.
// - Fast crystal stable flag at bit 3, set when stable and enabled.
// - Internal 8 MHz RC stable flag at bit 2, set when stable and enabled.
// - Slow crystal stable flag at bit 1, set when stable and enabled.
// - Internal 40 kHz RC stable flag at bit 0, set when stable and enabled.
// - APB2 soft-reset register at offset 0x0C, resets to all zeros.
// - Each soft-reset bit is plain read-write; while set, its peripheral is held in reset.
// - Timer resets at bits 21, 20, 19, 13 and 11.
// - GPIO port resets E..A at bits 6..2, resetting the whole port.
// - Alternate-function I/O held in reset while bit 0 is set.
// - Clear bits 22:16 are write-one; writing 0 has no effect.
// - Enables are read-write bits 14:8 in flag order.
// - Third PLL flag sits at bit 6.
//
// Register access over APB was decided locally.
`default_nettype none

// ----------------------------------------------------------------
// Next value of one stabilization flag
// ----------------------------------------------------------------
module crf_ready_flag_next
(
	input  wire logic stableSync,
	input  wire logic irqEn,
	input  wire logic armedPrev,
	input  wire logic flagCur,
	input  wire logic clearReq,
	output var  logic armedNow,
	output var  logic flagNext
);
	import crf_pkg::*;

	logic setEvent;

	always_comb
	begin
		// Set on the edge of stable-and-enabled, so a cleared flag stays clear while stable
		armedNow = stableSync & irqEn;
		setEvent = armedNow & ~armedPrev;
		// Clear wins over a same-cycle set; that set is then lost
		flagNext = clearReq ? 1'b0 : (flagCur | setEvent);
	end

endmodule

module crf_clock_ready_regs
(
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic [crf_pkg::ADDR_W-1:0] paddr,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [31:0]            pwdata,
	output var  logic [31:0]            prdata,
	output var  logic                   pready,
	output var  logic                   pslverr,
	input  wire crf_pkg::crf_src_t      oscReady,
	output var  crf_pkg::crf_apb2_rst_t periphSoftReset,
	output var  logic                   clockReadyIrq
);
	import crf_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [NUM_SRC-1:0] syncFirst;
		logic [NUM_SRC-1:0] syncSecond;
		logic [NUM_SRC-1:0] armedPrev;
		logic [NUM_SRC-1:0] readyFlag;
		logic [NUM_SRC-1:0] readyIrqEn;
		crf_apb2_rst_t      apb2PeriphSoftReset;
		logic [31:0]        rdata;
		logic               ready;
		logic               slverr;
		logic               irq;
	} crf_state_t;

	crf_state_t         state_reg;
	crf_state_t         state_next;
	logic               setupPhase;
	logic               accessDone;
	logic               hitIrqCtrl;
	logic               hitApb2Rst;
	wire logic [NUM_SRC-1:0] armed;
	wire logic [NUM_SRC-1:0] flagNext;
	logic [NUM_SRC-1:0] clrEv;
	logic [31:0]        irqCtrlRead;
	crf_apb2_rst_t      softWrite;
	crf_apb2_rst_t      softNext;

	// ----------------------------------------------------------------
	// Per-source flag logic
	// ----------------------------------------------------------------
	crf_ready_flag_next u_flag_third_pll
	(
		.stableSync (state_reg.syncSecond[SRC_THIRD_PLL]),
		.irqEn      (state_reg.readyIrqEn[SRC_THIRD_PLL]),
		.armedPrev  (state_reg.armedPrev[SRC_THIRD_PLL]),
		.flagCur    (state_reg.readyFlag[SRC_THIRD_PLL]),
		.clearReq   (clrEv[SRC_THIRD_PLL]),
		.armedNow   (armed[SRC_THIRD_PLL]),
		.flagNext   (flagNext[SRC_THIRD_PLL])
	);

	crf_ready_flag_next u_flag_second_pll
	(
		.stableSync (state_reg.syncSecond[SRC_SECOND_PLL]),
		.irqEn      (state_reg.readyIrqEn[SRC_SECOND_PLL]),
		.armedPrev  (state_reg.armedPrev[SRC_SECOND_PLL]),
		.flagCur    (state_reg.readyFlag[SRC_SECOND_PLL]),
		.clearReq   (clrEv[SRC_SECOND_PLL]),
		.armedNow   (armed[SRC_SECOND_PLL]),
		.flagNext   (flagNext[SRC_SECOND_PLL])
	);

	crf_ready_flag_next u_flag_main_pll
	(
		.stableSync (state_reg.syncSecond[SRC_MAIN_PLL]),
		.irqEn      (state_reg.readyIrqEn[SRC_MAIN_PLL]),
		.armedPrev  (state_reg.armedPrev[SRC_MAIN_PLL]),
		.flagCur    (state_reg.readyFlag[SRC_MAIN_PLL]),
		.clearReq   (clrEv[SRC_MAIN_PLL]),
		.armedNow   (armed[SRC_MAIN_PLL]),
		.flagNext   (flagNext[SRC_MAIN_PLL])
	);

	crf_ready_flag_next u_flag_fast_xtal
	(
		.stableSync (state_reg.syncSecond[SRC_FAST_XTAL]),
		.irqEn      (state_reg.readyIrqEn[SRC_FAST_XTAL]),
		.armedPrev  (state_reg.armedPrev[SRC_FAST_XTAL]),
		.flagCur    (state_reg.readyFlag[SRC_FAST_XTAL]),
		.clearReq   (clrEv[SRC_FAST_XTAL]),
		.armedNow   (armed[SRC_FAST_XTAL]),
		.flagNext   (flagNext[SRC_FAST_XTAL])
	);

	crf_ready_flag_next u_flag_rc8m
	(
		.stableSync (state_reg.syncSecond[SRC_RC8M]),
		.irqEn      (state_reg.readyIrqEn[SRC_RC8M]),
		.armedPrev  (state_reg.armedPrev[SRC_RC8M]),
		.flagCur    (state_reg.readyFlag[SRC_RC8M]),
		.clearReq   (clrEv[SRC_RC8M]),
		.armedNow   (armed[SRC_RC8M]),
		.flagNext   (flagNext[SRC_RC8M])
	);

	crf_ready_flag_next u_flag_slow_xtal
	(
		.stableSync (state_reg.syncSecond[SRC_SLOW_XTAL]),
		.irqEn      (state_reg.readyIrqEn[SRC_SLOW_XTAL]),
		.armedPrev  (state_reg.armedPrev[SRC_SLOW_XTAL]),
		.flagCur    (state_reg.readyFlag[SRC_SLOW_XTAL]),
		.clearReq   (clrEv[SRC_SLOW_XTAL]),
		.armedNow   (armed[SRC_SLOW_XTAL]),
		.flagNext   (flagNext[SRC_SLOW_XTAL])
	);

	crf_ready_flag_next u_flag_rc40k
	(
		.stableSync (state_reg.syncSecond[SRC_RC40K]),
		.irqEn      (state_reg.readyIrqEn[SRC_RC40K]),
		.armedPrev  (state_reg.armedPrev[SRC_RC40K]),
		.flagCur    (state_reg.readyFlag[SRC_RC40K]),
		.clearReq   (clrEv[SRC_RC40K]),
		.armedNow   (armed[SRC_RC40K]),
		.flagNext   (flagNext[SRC_RC40K])
	);

	// ----------------------------------------------------------------
	// Write-one clear decode
	// ----------------------------------------------------------------
	always_comb
	begin
		clrEv = '0;
		if (accessDone && pwrite && hitIrqCtrl)
		begin
			clrEv = pwdata[CLR_LSB +: NUM_SRC];
		end
	end

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		setupPhase = psel & ~penable;
		accessDone = psel & penable & state_reg.ready;
		hitIrqCtrl = (paddr == OFFS_CLOCK_READY_IRQ_CTRL);
		hitApb2Rst = (paddr == OFFS_APB2_PERIPH_SOFT_RESET);

		// Two-stage synchroniser on the asynchronous stable indications
		state_next.syncFirst = oscReady;
		state_next.syncSecond = state_reg.syncFirst;

		// Edge memory for the per-source flag logic
		state_next.armedPrev = armed;
		softWrite = crf_apb2_rst_t'(pwdata);
		softNext = crf_apb2_rst_t'(APB2_RST_RESET);

		if (accessDone && pwrite && hitIrqCtrl)
		begin
			state_next.readyIrqEn = pwdata[EN_LSB +: NUM_SRC];
		end

		state_next.readyFlag = flagNext;

		// Soft-reset bits change only by software; reserved bits stay zero
		if (accessDone && pwrite && hitApb2Rst)
		begin
			softNext.timerTenSoftReset = softWrite.timerTenSoftReset;
			softNext.timerNineSoftReset = softWrite.timerNineSoftReset;
			softNext.timerEightSoftReset = softWrite.timerEightSoftReset;
			softNext.firstSerialPortSoftReset = softWrite.firstSerialPortSoftReset;
			softNext.timerSevenSoftReset = softWrite.timerSevenSoftReset;
			softNext.firstSpiSoftReset = softWrite.firstSpiSoftReset;
			softNext.timerZeroSoftReset = softWrite.timerZeroSoftReset;
			softNext.secondAdcSoftReset = softWrite.secondAdcSoftReset;
			softNext.firstAdcSoftReset = softWrite.firstAdcSoftReset;
			softNext.portESoftReset = softWrite.portESoftReset;
			softNext.portDSoftReset = softWrite.portDSoftReset;
			softNext.portCSoftReset = softWrite.portCSoftReset;
			softNext.portBSoftReset = softWrite.portBSoftReset;
			softNext.portASoftReset = softWrite.portASoftReset;
			softNext.altfuncIoSoftReset = softWrite.altfuncIoSoftReset;
			state_next.apb2PeriphSoftReset = softNext;
		end

		// Interrupt level follows enabled flags
		state_next.irq = |(state_next.readyFlag & state_next.readyIrqEn);

		// Clear bits and bit 7 read as zero
		irqCtrlRead = '0;
		irqCtrlRead[FLAG_LSB +: NUM_SRC] = state_reg.readyFlag;
		irqCtrlRead[EN_LSB +: NUM_SRC] = state_reg.readyIrqEn;

		// Answer is prepared in the setup cycle and shown in the access cycle
		state_next.ready = setupPhase;
		state_next.slverr = setupPhase & ~(hitIrqCtrl | hitApb2Rst);
		if (setupPhase)
		begin
			if (pwrite)
			begin
				state_next.rdata = '0;
			end
			else if (hitIrqCtrl)
			begin
				state_next.rdata = irqCtrlRead;
			end
			else if (hitApb2Rst)
			begin
				state_next.rdata = state_reg.apb2PeriphSoftReset;
			end
			else
			begin
				state_next.rdata = '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_reg <= '0;
			state_reg.readyFlag <= IRQ_CTRL_RESET[FLAG_LSB +: NUM_SRC];
			state_reg.readyIrqEn <= IRQ_CTRL_RESET[EN_LSB +: NUM_SRC];
			state_reg.apb2PeriphSoftReset <= crf_apb2_rst_t'(APB2_RST_RESET);
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb
	begin
		prdata = state_reg.rdata;
		pready = state_reg.ready;
		pslverr = state_reg.slverr;
		periphSoftReset = state_reg.apb2PeriphSoftReset;
		clockReadyIrq = state_reg.irq;
	end

endmodule

`default_nettype wire

// ---- pkg/crf_pkg.sv ----
// Constants and types for the clock-ready flags and APB2 peripheral soft-reset block.
// Assumes a 32-bit APB slave on one system clock.
`default_nettype none

package crf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFFS_CLOCK_READY_IRQ_CTRL = 12'h008;
	localparam logic [ADDR_W-1:0] OFFS_APB2_PERIPH_SOFT_RESET = 12'h00c;

	// ----------------------------------------------------------------
	// Clock interrupt register layout
	// ----------------------------------------------------------------
	localparam int NUM_SRC = 7;
	localparam int FLAG_LSB = 0;
	localparam int EN_LSB = 8;
	localparam int CLR_LSB = 16;
	localparam logic [31:0] IRQ_CTRL_RESET = 32'h0000_0000;

	localparam int SRC_RC40K = 0;
	localparam int SRC_SLOW_XTAL = 1;
	localparam int SRC_RC8M = 2;
	localparam int SRC_FAST_XTAL = 3;
	localparam int SRC_MAIN_PLL = 4;
	localparam int SRC_SECOND_PLL = 5;
	localparam int SRC_THIRD_PLL = 6;

	// ----------------------------------------------------------------
	// APB2 soft-reset register layout
	// ----------------------------------------------------------------
	localparam logic [31:0] APB2_RST_RESET = 32'h0000_0000;
	localparam logic [31:0] APB2_RST_WR_MASK = 32'h0038_7e7d;

	// Oscillator and PLL stable indications, bit order equals flag order
	typedef struct packed {
		logic thirdPll;
		logic secondPll;
		logic mainPll;
		logic fastCrystalOsc;
		logic rc8mInternalOsc;
		logic slowCrystalOsc;
		logic rc40kInternalOsc;
	} crf_src_t;

	typedef struct packed {
		logic [9:0] rsvd31;
		logic       timerTenSoftReset;
		logic       timerNineSoftReset;
		logic       timerEightSoftReset;
		logic [3:0] rsvd18;
		logic       firstSerialPortSoftReset;
		logic       timerSevenSoftReset;
		logic       firstSpiSoftReset;
		logic       timerZeroSoftReset;
		logic       secondAdcSoftReset;
		logic       firstAdcSoftReset;
		logic [1:0] rsvd8;
		logic       portESoftReset;
		logic       portDSoftReset;
		logic       portCSoftReset;
		logic       portBSoftReset;
		logic       portASoftReset;
		logic       rsvd1;
		logic       altfuncIoSoftReset;
	} crf_apb2_rst_t;

endpackage

`default_nettype wire

// ---- verification/crf_properties.sv ----
// Checker of bus timing and soft-reset register relations at the block's ports.
// Assumes one clock domain and the zero-wait APB slave of the block.
`default_nettype none
module crf_properties
(
	input wire logic                   core_clk,
	input wire logic                   rst,
	input wire logic [crf_pkg::ADDR_W-1:0] paddr,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire crf_pkg::crf_src_t      oscReady,
	input wire crf_pkg::crf_apb2_rst_t periphSoftReset,
	input wire logic                   clockReadyIrq
);
	timeunit 1ns;
	timeprecision 1ns;
	import crf_pkg::*;
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence wrSoft;
		psel && penable && pready && pwrite && paddr == OFFS_APB2_PERIPH_SOFT_RESET;
	endsequence
	pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	setup_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
	unmapped_err_a: assert property (pready && pslverr |-> paddr != OFFS_APB2_PERIPH_SOFT_RESET
		&& paddr != OFFS_CLOCK_READY_IRQ_CTRL) else $error("error on mapped address");
	err_data_a: assert property (pslverr && !pwrite |-> prdata == '0) else $error("error data");
	ctrl_read_a: assert property (pready && !pwrite && paddr == OFFS_CLOCK_READY_IRQ_CTRL
		|-> prdata[31:15] == '0 && !prdata[7]) else $error("clear bits read back");
	soft_write_a: assert property (wrSoft |=>
		periphSoftReset == ($past(pwdata) & APB2_RST_WR_MASK)) else $error("write lost");
	soft_hold_a: assert property (!(pready && pwrite) |=> $stable(periphSoftReset))
		else $error("soft reset changed by itself");
	reserved_zero_a: assert property ((periphSoftReset & ~APB2_RST_WR_MASK) == '0)
		else $error("reserved bit set");
endmodule
bind crf_clock_ready_regs crf_properties u_props (.core_clk, .rst, .paddr, .psel, .penable,
	.pwrite, .pwdata, .prdata, .pready, .pslverr, .oscReady, .periphSoftReset, .clockReadyIrq);
`default_nettype wire

// ---- verification/tb_clock_ready_flags_and_apb2_reset.sv ----
// Testbench: soft-reset field map over APB, then stability flags, interrupt and clears.
// Assumes the block's zero-wait APB slave and a 20 MHz system clock.
`default_nettype none
module tb_clock_ready_flags_and_apb2_reset;
	timeunit 1ns;
	timeprecision 1ns;
	import crf_pkg::*;
	logic              core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rdData;
	logic              pready, pslverr, clockReadyIrq, rdErr;
	crf_src_t          oscReady = '0;
	crf_apb2_rst_t     periphSoftReset;
	int                nMismatch = 0, checksDone = 0;
	logic [31:0] rowIn [8] = '{32'h0038_7e7d, 32'h0020_0000, 32'h0018_2800, 32'h0000_5600,
		32'h0000_007c, 32'h0000_0001, 32'h0008_0200, 32'h0};
	logic [31:0] rowOut [8] = '{32'h0038_7e7d, 32'h0020_0000, 32'h0018_2800, 32'h0000_5600,
		32'h0000_007c, 32'h0000_0001, 32'h0008_0200, 32'h0};
	always #25 core_clk = ~core_clk;
	crf_clock_ready_regs dut (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .oscReady(oscReady),
		.periphSoftReset(periphSoftReset), .clockReadyIrq(clockReadyIrq));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		#100000;
		nMismatch++;
		tally_and_finish;
	end
	initial
	begin
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		apb(OFFS_APB2_PERIPH_SOFT_RESET, 0, 0);
		chk(rdData, 32'h0);
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 0, 0);
		chk(rdData, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			apb(OFFS_APB2_PERIPH_SOFT_RESET, 1, rowIn[i]);
			wt(2);
			chk(periphSoftReset, rowOut[i]);
			apb(OFFS_APB2_PERIPH_SOFT_RESET, 0, 0);
			chk(rdData, rowOut[i]);
		end
		apb(12'h010, 0, 0);
		chk({rdData[31:1], rdErr}, 32'h1);
		oscReady <= '1;
		wt(6);
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 0, 0);
		chk(rdData, 32'h0);
		chk({31'h0, clockReadyIrq}, 32'h0);
		oscReady <= '0;
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 1, 32'h7f00);
		for (int i = 0; i < NUM_SRC; i++)
		begin
			oscReady <= crf_src_t'(7'h1 << i);
			wt(6);
			apb(OFFS_CLOCK_READY_IRQ_CTRL, 0, 0);
			chk(rdData, 32'h7f00 | (32'h1 << i));
			chk({31'h0, clockReadyIrq}, 32'h1);
			apb(OFFS_CLOCK_READY_IRQ_CTRL, 1, 32'h0);
			oscReady <= '0;
			wt(4);
			chk({31'h0, clockReadyIrq}, 32'h0);
			apb(OFFS_CLOCK_READY_IRQ_CTRL, 0, 0);
			chk(rdData, 32'h1 << i);
			apb(OFFS_CLOCK_READY_IRQ_CTRL, 1, 32'h7f00 | (32'h1_0000 << i));
			wt(2);
			apb(OFFS_CLOCK_READY_IRQ_CTRL, 0, 0);
			chk(rdData, 32'h7f00);
			chk({31'h0, clockReadyIrq}, 32'h0);
		end
		// Stable edge of the main PLL meets its clear in the same cycle
		oscReady <= 7'h10;
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 1, 32'h0010_7f00);
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 0, 0);
		chk(rdData, 32'h7f00);
		chk({31'h0, clockReadyIrq}, 32'h0);
		// Enable raised while the source is already stable
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 1, 32'h0);
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 1, 32'h7f00);
		wt(4);
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 0, 0);
		chk(rdData, 32'h7f10);
		chk({31'h0, clockReadyIrq}, 32'h1);
		apb(OFFS_APB2_PERIPH_SOFT_RESET, 1, 32'h0038_7e7d);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		wt(1);
		chk(periphSoftReset, 32'h0);
		chk({31'h0, clockReadyIrq}, 32'h0);
		apb(OFFS_CLOCK_READY_IRQ_CTRL, 0, 0);
		chk(rdData, 32'h0);
		tally_and_finish;
	end
endmodule
`default_nettype wire
